// file: verilog/seqbuf_port.sv
// Purpose: Sequential port pointer, flags and command access
// Assumes: All pins sampled on CORE_CLK; ARST_N is the master reset
// Notes: Random-port memory access is outside this block
`timescale 1ns/10ps
module seqbuf_port
    import seqbuf_pkg::*;
(
    // Clock and reset
    input logic CORE_CLK,
    input logic ARST_N,
    // Sequential control
    input logic SEQ_PORT_SELECT_N,
    input logic COUNT_ADVANCE_EN_N,
    input logic SEQ_READ_WRITE,
    input logic SEQ_OUTPUT_EN_N,
    // Sequential data pins
    input logic [15:0] SEQ_DATA_IN,
    output logic [15:0] SEQ_DATA_OUT,
    output logic SEQ_DATA_OE_N,
    // Pointer operations
    input logic POINTER_LOAD_N,
    input logic JUMP_START_ONE_N,
    input logic JUMP_START_TWO_N,
    // End flags
    output logic END_FLAG_ONE_N,
    output logic END_FLAG_TWO_N,
    // Random port command access
    input logic REGISTER_ACCESS_SEL_N,
    input logic CHIP_SELECT_N,
    input logic RAND_READ_WRITE,
    input logic [2:0] REGISTER_SELECT_BITS,
    input logic [15:0] RAND_DATA_IN,
    output logic [15:0] RAND_DATA_OUT,
    output logic RAND_DATA_OE_N
);
    ptr_state_t ptr_state_r;
    logic [12:0] pointer_r;
    logic [12:0] pointer_nxt;
    logic [12:0] load_hold_r;
    logic halted_r;
    logic halted_nxt;
    logic [1:0] status_r;
    logic [1:0] hit;
    logic [1:0] set_ev;
    logic [12:0] start_one;
    logic [12:0] end_one;
    logic [12:0] start_two;
    logic [12:0] end_two;
    logic [1:0] mode_one;
    logic [1:0] mode_two;
    logic release_pulse;
    logic [1:0] flag_clear;
    logic selected;
    logic seq_read;
    logic seq_write;
    logic advance;
    logic jump;
    logic cmd_acc;

    function automatic logic [12:0] inc_ptr(input logic [12:0] p);
        inc_ptr = p + 13'h0001;
    endfunction

    function automatic logic [1:0] mode_of(input int idx,
                                           input logic [1:0] m1,
                                           input logic [1:0] m2);
        mode_of = (idx == 0) ? m1 : m2;
    endfunction

    assign cmd_acc = !REGISTER_ACCESS_SEL_N && CHIP_SELECT_N;
    assign selected = !SEQ_PORT_SELECT_N;
    assign jump = !JUMP_START_ONE_N || !JUMP_START_TWO_N;
    assign seq_read = selected && SEQ_READ_WRITE;
    // Stop mode blocks writes until a release, a jump or a pointer load
    assign seq_write = selected && !SEQ_READ_WRITE && !halted_r;
    assign advance = selected && !COUNT_ADVANCE_EN_N && !halted_r
        && ptr_state_r == PTR_IDLE && POINTER_LOAD_N && !jump;
    // end address reached on an advancing edge
    assign hit = {pointer_r == end_two, pointer_r == end_one} &
        {2{advance}};
    assign set_ev = hit;

    // pointer next value and flow behaviour
    always_comb begin
        pointer_nxt = pointer_r;
        halted_nxt = halted_r;
        if (release_pulse) begin
            halted_nxt = 1'b0;
        end
        if (ptr_state_r == PTR_LOAD_PEND) begin
            pointer_nxt = load_hold_r;
            halted_nxt = 1'b0;
        end else if (!JUMP_START_ONE_N && POINTER_LOAD_N) begin
            pointer_nxt = start_one;
            halted_nxt = 1'b0;
        end else if (!JUMP_START_TWO_N && POINTER_LOAD_N) begin
            pointer_nxt = start_two;
            halted_nxt = 1'b0;
        end else if (!POINTER_LOAD_N) begin
            halted_nxt = 1'b0;
        end else if (advance) begin
            pointer_nxt = inc_ptr(pointer_r);
            // chaining, equal ends go to buffer one when buffer two chains
            if (hit[1] && mode_two == MODE_CHAIN) begin
                pointer_nxt = start_one;
            end
            if (hit[0] && mode_one == MODE_CHAIN && !hit[1]) begin
                pointer_nxt = start_two;
            end
            if ((hit[0] && mode_one == MODE_STOP)
                || (hit[1] && mode_two == MODE_STOP)) begin
                halted_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pointer_r <= RST_POINTER;
            halted_r <= 1'b0;
        end else begin
            pointer_r <= pointer_nxt;
            halted_r <= halted_nxt;
        end
    end

    // two-cycle pointer load from data pins
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ptr_state_r <= PTR_IDLE;
            load_hold_r <= RST_POINTER;
        end else begin
            case (ptr_state_r)
                PTR_IDLE: begin
                    if (!POINTER_LOAD_N) begin
                        load_hold_r <= SEQ_DATA_IN[12:0];
                        ptr_state_r <= PTR_LOAD_PEND;
                    end
                end
                PTR_LOAD_PEND: ptr_state_r <= PTR_IDLE;
                default: ptr_state_r <= PTR_IDLE;
            endcase
        end
    end

    // flags; a set beats a clear in the same cycle
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            status_r <= 2'b00;
            END_FLAG_ONE_N <= 1'b1;
            END_FLAG_TWO_N <= 1'b1;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (set_ev[i]) begin
                    status_r[i] <= 1'b1;
                end else if (flag_clear[i]) begin
                    status_r[i] <= 1'b0;
                end
            end
            // mask mode keeps the pin high
            if (set_ev[0] && mode_one != MODE_MASK) begin
                END_FLAG_ONE_N <= 1'b0;
            end else if (flag_clear[0]) begin
                END_FLAG_ONE_N <= 1'b1;
            end
            if (set_ev[1] && mode_of(1, mode_one, mode_two) != MODE_MASK)
            begin
                END_FLAG_TWO_N <= 1'b0;
            end else if (flag_clear[1]) begin
                END_FLAG_TWO_N <= 1'b1;
            end
        end
    end

    // bus drive only on a selected, enabled read
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            SEQ_DATA_OE_N <= 1'b1;
        end else begin
            SEQ_DATA_OE_N <= !(seq_read && !SEQ_OUTPUT_EN_N);
        end
    end

    // word store, read of current pointer
    seqbuf_mem u_mem (
        .clk(CORE_CLK),
        .arst_n(ARST_N),
        .wr_en(seq_write),
        .rd_en(seq_read && !SEQ_OUTPUT_EN_N),
        .addr(pointer_r),
        .wr_data(SEQ_DATA_IN),
        .rd_data(SEQ_DATA_OUT)
    );

    seqbuf_cmd u_cmd (
        .clk(CORE_CLK),
        .arst_n(ARST_N),
        .cmd_acc(cmd_acc),
        .rand_read_write(RAND_READ_WRITE),
        .register_select_bits(REGISTER_SELECT_BITS),
        .rand_data_in(RAND_DATA_IN),
        .rand_data_out(RAND_DATA_OUT),
        .rand_data_oe_n(RAND_DATA_OE_N),
        .flag_status(status_r),
        .halted(halted_r),
        .start_one(start_one),
        .end_one(end_one),
        .start_two(start_two),
        .end_two(end_two),
        .mode_one(mode_one),
        .mode_two(mode_two),
        .release_pulse(release_pulse),
        .flag_clear(flag_clear)
    );
endmodule

// file: verilog/seqbuf_pkg.sv
// Purpose: Shared constants for the sequential buffer port
// Assumes: One 10 MHz clock, all pins synchronous to it
package seqbuf_pkg;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 16;
    localparam int MEM_DEPTH = 8192;

    // Command selects
    localparam logic [2:0] SEL_START_ONE = 3'h0;
    localparam logic [2:0] SEL_END_ONE = 3'h1;
    localparam logic [2:0] SEL_START_TWO = 3'h2;
    localparam logic [2:0] SEL_END_TWO = 3'h3;
    localparam logic [2:0] SEL_FLOW = 3'h4;
    localparam logic [2:0] SEL_FLAGS = 3'h5;

    // Reset values
    localparam logic [12:0] RST_START_ONE = 13'h0000;
    localparam logic [12:0] RST_END_ONE = 13'h1000;
    localparam logic [12:0] RST_START_TWO = 13'h1000;
    localparam logic [12:0] RST_END_TWO = 13'h1fff;
    localparam logic [12:0] RST_POINTER = 13'h0000;

    // Flow control field positions
    localparam int FLOW_ONE_LSB = 0;
    localparam int FLOW_TWO_LSB = 2;
    localparam int FLOW_RELEASE_BIT = 4;

    // Flow modes
    localparam logic [1:0] MODE_CHAIN = 2'h0;
    localparam logic [1:0] MODE_STOP = 2'h1;
    localparam logic [1:0] MODE_LINEAR = 2'h2;
    localparam logic [1:0] MODE_MASK = 2'h3;

    localparam logic [15:0] ILLEGAL_READ = 16'hffff;

    typedef enum logic {PTR_IDLE, PTR_LOAD_PEND} ptr_state_t;
endpackage

// file: verilog/seqbuf_mem.sv
// Purpose: Word store behind the sequential port
// Assumes: Single clock, one access per cycle
// Notes: Read data is registered and drives the pin directly
`timescale 1ns/10ps
module seqbuf_mem
    import seqbuf_pkg::*;
(
    // Clock and reset
    input logic clk,
    input logic arst_n,
    // Access
    input logic wr_en,
    input logic rd_en,
    input logic [12:0] addr,
    input logic [15:0] wr_data,
    output logic [15:0] rd_data
);
    logic [15:0] mem [0:MEM_DEPTH-1];

    // No reset on the array; contents are undefined at power up
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= 16'h0000;
        end else if (rd_en) begin
            rd_data <= mem[addr];
        end
    end
endmodule

// file: verilog/seqbuf_cmd.sv
// Purpose: Command register file reached from the random port
// Assumes: Command strobe already qualified by the caller
// Notes: Flag clear and release are one-cycle pulses
`timescale 1ns/10ps
module seqbuf_cmd
    import seqbuf_pkg::*;
(
    // Clock and reset
    input logic clk,
    input logic arst_n,
    // Command access
    input logic cmd_acc,
    input logic rand_read_write,
    input logic [2:0] register_select_bits,
    input logic [15:0] rand_data_in,
    output logic [15:0] rand_data_out,
    output logic rand_data_oe_n,
    // Block state
    input logic [1:0] flag_status,
    input logic halted,
    output logic [12:0] start_one,
    output logic [12:0] end_one,
    output logic [12:0] start_two,
    output logic [12:0] end_two,
    output logic [1:0] mode_one,
    output logic [1:0] mode_two,
    output logic release_pulse,
    output logic [1:0] flag_clear
);
    logic wr;
    logic [12:0] wdat;
    logic [15:0] rd_nxt;

    assign wr = cmd_acc && !rand_read_write;
    assign wdat = rand_data_in[12:0];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            start_one <= RST_START_ONE;
            end_one <= RST_END_ONE;
            start_two <= RST_START_TWO;
            end_two <= RST_END_TWO;
            mode_one <= MODE_CHAIN;
            mode_two <= MODE_CHAIN;
        end else if (wr) begin
            case (register_select_bits)
                SEL_START_ONE: start_one <= wdat;
                SEL_END_ONE: end_one <= wdat;
                SEL_START_TWO: start_two <= wdat;
                SEL_END_TWO: end_two <= wdat;
                SEL_FLOW: begin
                    mode_one <= wdat[FLOW_ONE_LSB +: 2];
                    mode_two <= wdat[FLOW_TWO_LSB +: 2];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            release_pulse <= 1'b0;
            flag_clear <= 2'b00;
        end else begin
            release_pulse <= wr && register_select_bits == SEL_FLOW
                && !wdat[FLOW_RELEASE_BIT];
            flag_clear <= (wr && register_select_bits == SEL_FLAGS)
                ? ~wdat[1:0] : 2'b00;
        end
    end

    always_comb begin
        rd_nxt = 16'h0000;
        case (register_select_bits)
            SEL_START_ONE: rd_nxt[12:0] = start_one;
            SEL_END_ONE: rd_nxt[12:0] = end_one;
            SEL_START_TWO: rd_nxt[12:0] = start_two;
            SEL_END_TWO: rd_nxt[12:0] = end_two;
            SEL_FLOW: begin
                rd_nxt[FLOW_ONE_LSB +: 2] = mode_one;
                rd_nxt[FLOW_TWO_LSB +: 2] = mode_two;
                rd_nxt[FLOW_RELEASE_BIT] = halted;
            end
            SEL_FLAGS: rd_nxt[1:0] = flag_status;
            default: rd_nxt = ILLEGAL_READ;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rand_data_out <= 16'h0000;
            rand_data_oe_n <= 1'b1;
        end else begin
            rand_data_out <= rd_nxt;
            rand_data_oe_n <= !(cmd_acc && rand_read_write);
        end
    end
endmodule

// file: verification/seqbuf_port_sva.sv
// Purpose: Port checks for the sequential buffer port
// Assumes: One clock, ARST_N async active low
// Notes: Flag hold skips the cycle a command clear lands
`timescale 1ns/10ps
module seqbuf_port_sva (
    // Clock and reset
    input logic CORE_CLK,
    input logic ARST_N,
    // Sequential side
    input logic SEQ_PORT_SELECT_N,
    input logic COUNT_ADVANCE_EN_N,
    input logic SEQ_READ_WRITE,
    input logic SEQ_OUTPUT_EN_N,
    input logic POINTER_LOAD_N,
    input logic JUMP_START_ONE_N,
    input logic JUMP_START_TWO_N,
    input logic [15:0] SEQ_DATA_OUT,
    input logic SEQ_DATA_OE_N,
    input logic END_FLAG_ONE_N,
    input logic END_FLAG_TWO_N,
    // Command side
    input logic REGISTER_ACCESS_SEL_N,
    input logic CHIP_SELECT_N,
    input logic RAND_READ_WRITE,
    input logic [2:0] REGISTER_SELECT_BITS,
    input logic [15:0] RAND_DATA_OUT,
    input logic RAND_DATA_OE_N
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);
    logic cmd_rd;
    logic sel_rd;
    assign cmd_rd = !REGISTER_ACCESS_SEL_N && CHIP_SELECT_N && RAND_READ_WRITE;
    assign sel_rd = !SEQ_PORT_SELECT_N && SEQ_READ_WRITE;
    // Pointer ops excluded: a load moves the pointer a cycle late
    sequence hold_rd;
        sel_rd && COUNT_ADVANCE_EN_N && !SEQ_OUTPUT_EN_N &&
            POINTER_LOAD_N && JUMP_START_ONE_N && JUMP_START_TWO_N;
    endsequence
    read_drive_a: assert property (
        sel_rd && !SEQ_OUTPUT_EN_N |=> !SEQ_DATA_OE_N)
        else $error("Read did not drive the bus");
    hold_word_a: assert property (hold_rd [*3] |=> $stable(SEQ_DATA_OUT))
        else $error("Held read changed the word");
    oe_float_a: assert property (SEQ_OUTPUT_EN_N |=> SEQ_DATA_OE_N)
        else $error("Bus driven with output enable high");
    write_float_a: assert property (
        !SEQ_PORT_SELECT_N && !SEQ_READ_WRITE |=> SEQ_DATA_OE_N)
        else $error("Bus driven during write");
    desel_float_a: assert property (SEQ_PORT_SELECT_N |=> SEQ_DATA_OE_N)
        else $error("Bus driven while deselected");
    flags_hold_a: assert property (
        SEQ_PORT_SELECT_N && REGISTER_ACCESS_SEL_N &&
            $past(REGISTER_ACCESS_SEL_N)
        |=> $stable({END_FLAG_ONE_N, END_FLAG_TWO_N}))
        else $error("Flags moved while deselected");
    illegal_read_a: assert property (
        cmd_rd && REGISTER_SELECT_BITS[2:1] == 2'h3
        |=> RAND_DATA_OUT == 16'hffff && !RAND_DATA_OE_N)
        else $error("Reserved select did not read all ones");
    cmd_upper_a: assert property (
        cmd_rd && REGISTER_SELECT_BITS[2:1] != 2'h3
        |=> RAND_DATA_OUT[15:13] == 3'h0 && !RAND_DATA_OE_N)
        else $error("Command read upper bits not zero");
    cmd_idle_a: assert property (
        REGISTER_ACCESS_SEL_N || !CHIP_SELECT_N |=> RAND_DATA_OE_N)
        else $error("Random bus driven outside command mode");
    cover property (hold_rd [*3]);
    cover property (cmd_rd ##1 !RAND_DATA_OE_N);
    cover property ($fell(END_FLAG_ONE_N));
endmodule

bind seqbuf_port seqbuf_port_sva chk_u (
    .CORE_CLK(CORE_CLK), .ARST_N(ARST_N),
    .SEQ_PORT_SELECT_N(SEQ_PORT_SELECT_N),
    .COUNT_ADVANCE_EN_N(COUNT_ADVANCE_EN_N),
    .SEQ_READ_WRITE(SEQ_READ_WRITE), .SEQ_OUTPUT_EN_N(SEQ_OUTPUT_EN_N),
    .POINTER_LOAD_N(POINTER_LOAD_N), .JUMP_START_ONE_N(JUMP_START_ONE_N),
    .JUMP_START_TWO_N(JUMP_START_TWO_N), .SEQ_DATA_OUT(SEQ_DATA_OUT),
    .SEQ_DATA_OE_N(SEQ_DATA_OE_N), .END_FLAG_ONE_N(END_FLAG_ONE_N),
    .END_FLAG_TWO_N(END_FLAG_TWO_N),
    .REGISTER_ACCESS_SEL_N(REGISTER_ACCESS_SEL_N),
    .CHIP_SELECT_N(CHIP_SELECT_N), .RAND_READ_WRITE(RAND_READ_WRITE),
    .REGISTER_SELECT_BITS(REGISTER_SELECT_BITS),
    .RAND_DATA_OUT(RAND_DATA_OUT), .RAND_DATA_OE_N(RAND_DATA_OE_N)
);

// file: verification/seqbuf_host.sv
// Purpose: Host end of the shared sequential data bus
// Assumes: Host drives only for writes and pointer loads
// Notes: Undriven bus toggles so stale data never passes
`timescale 1ns/10ps
module seqbuf_host (
    // Clock
    input logic clk,
    // Device side
    input logic [15:0] dev_data,
    input logic dev_oe_n,
    // Host side
    input logic [15:0] host_data,
    input logic host_oe_n,
    // Resolved bus
    output logic [15:0] bus,
    output logic clash
);
    logic [15:0] last_r;
    initial clash = 1'b0;
    initial last_r = 16'h0000;
    always_comb begin
        if (!dev_oe_n)
            bus = dev_data;
        else if (!host_oe_n)
            bus = host_data;
        else
            bus = ~last_r;
    end
    always @(posedge clk) begin
        last_r <= bus;
        if (!dev_oe_n && !host_oe_n)
            clash <= 1'b1;
    end
endmodule

// file: verification/tb_top.sv
// Purpose: Self-checking bench for the sequential buffer port
// Assumes: 10 MHz clock, reset low for 20 cycles
// Notes: Outputs are sampled 1 ns after each drive edge
`timescale 1ns/10ps
module tb_top
    import seqbuf_pkg::*;
;
    localparam logic [6:0] IDL = 7'h7f, RD = 7'h17, RDH = 7'h37;
    localparam logic [6:0] WR = 7'h0f, RNO = 7'h1f, J1 = 7'h7d, LD = 7'h1b;
    localparam logic [6:0] J2 = 7'h7e;
    logic core_clk, arst_n, sel_n, cnt_n, rw, oe_n, ld_n, j1_n, j2_n;
    logic reg_n, cs_n, rrw, soe_n, f1_n, f2_n, roe_n, hoe_n, clash;
    logic [2:0] rsel;
    logic [15:0] rdin, hdata, sbus, sout, rout, exp_w;
    logic [15:0] bv [4] = '{16'h0010, 16'h0013, 16'h0020, 16'h0022};
    logic [15:0] rv [5] = '{{3'h0, RST_START_ONE}, {3'h0, RST_END_ONE},
        {3'h0, RST_START_TWO}, {3'h0, RST_END_TWO}, 16'h0000};
    int errors, tests_run;
    seqbuf_port dut_u (.CORE_CLK(core_clk), .ARST_N(arst_n),
        .SEQ_PORT_SELECT_N(sel_n), .COUNT_ADVANCE_EN_N(cnt_n),
        .SEQ_READ_WRITE(rw), .SEQ_OUTPUT_EN_N(oe_n), .SEQ_DATA_IN(sbus),
        .SEQ_DATA_OUT(sout), .SEQ_DATA_OE_N(soe_n), .POINTER_LOAD_N(ld_n),
        .JUMP_START_ONE_N(j1_n), .JUMP_START_TWO_N(j2_n),
        .END_FLAG_ONE_N(f1_n), .END_FLAG_TWO_N(f2_n),
        .REGISTER_ACCESS_SEL_N(reg_n), .CHIP_SELECT_N(cs_n),
        .RAND_READ_WRITE(rrw), .REGISTER_SELECT_BITS(rsel),
        .RAND_DATA_IN(rdin), .RAND_DATA_OUT(rout), .RAND_DATA_OE_N(roe_n));
    seqbuf_host host_u (.clk(core_clk), .dev_data(sout), .dev_oe_n(soe_n),
        .host_data(hdata), .host_oe_n(hoe_n), .bus(sbus), .clash(clash));
    always #50 core_clk = ~core_clk;
    task automatic chk(input string what, input logic [15:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Host drives only for a selected write or a pointer load
    task automatic cyc(input logic [6:0] c, input logic [15:0] d);
        @(posedge core_clk);
        {sel_n, cnt_n, rw, oe_n, ld_n, j1_n, j2_n} <= c;
        hdata <= d;
        hoe_n <= ~(~c[2] | (~c[6] & ~c[4]));
        #1;
    endtask
    task automatic cmd(input logic w, input logic [2:0] s,
        input logic [15:0] d, exp);
        @(posedge core_clk);
        {reg_n, rrw, rsel, rdin} <= {1'b0, ~w, s, d};
        @(posedge core_clk);
        reg_n <= 1'b1;
        #1;
        if (!w)
            chk("command read", rout, exp);
    endtask
    task automatic end_of_test;
        $display("Checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge core_clk);
        errors++;
        end_of_test();
    end
    initial begin
        {core_clk, arst_n, hoe_n, rsel, rdin, hdata} = '0;
        {sel_n, cnt_n, rw, oe_n, ld_n, j1_n, j2_n} = IDL;
        {reg_n, cs_n, rrw, hoe_n} = 4'hf;
        repeat (20) @(posedge core_clk);
        arst_n <= 1'b1;
        chk("flags", {f1_n, f2_n, soe_n}, 3'h7);
        for (int i = 0; i < 5; i++)
            cmd(1'b0, 3'(i), 16'h0, rv[i]);
        for (int i = 0; i < 4; i++) begin
            cmd(1'b1, 3'(i), 16'he000 | bv[i], 16'h0);
            cmd(1'b0, 3'(i), 16'h0, bv[i]);
        end
        cmd(1'b0, 3'h6, 16'h0, 16'hffff);
        cmd(1'b0, 3'h7, 16'h0, 16'hffff);
        cmd(1'b1, SEL_FLOW, {14'h0, MODE_LINEAR}, 16'h0);
        cmd(1'b0, SEL_FLOW, 16'h0, {14'h0, MODE_LINEAR});
        $display("Test registers done");
        cyc(J1, 16'h0);
        for (int i = 0; i < 4; i++)
            cyc(WR, 16'h1000 + 16'(i));
        cyc(IDL, 16'h0);
        chk("end flags", {f1_n, f2_n}, 2'h1);
        cmd(1'b0, SEL_FLAGS, 16'h0, 16'h0001);
        cyc(J1, 16'h0);
        for (int i = 0; i < 5; i++) begin
            cyc(i < 4 ? RD : RDH, 16'h0);
            if (i > 0)
                chk("read", sout, 16'h1000 + 16'(i - 1));
        end
        cyc(J1, 16'h0);
        for (int i = 0; i < 3; i++)
            cyc(RDH, 16'h0);
        chk("hold", sout, 16'h1000);
        cyc(RD, 16'h0);
        chk("hold", sout, 16'h1000);
        cyc(RNO, 16'h0);
        cyc(RD, 16'h0);
        chk("no output", soe_n, 1'b1);
        cyc(IDL, 16'h0);
        chk("silent count", sout, 16'h1002);
        $display("Test stream done");
        cmd(1'b1, SEL_FLAGS, 16'h0, 16'h0);
        cyc(IDL, 16'h0);
        chk("cleared", {f1_n, f2_n}, 2'h3);
        cmd(1'b0, SEL_FLAGS, 16'h0, 16'h0);
        $display("Test flags done");
        cyc(LD, 16'he010);
        for (int i = 0; i < 3; i++)
            cyc(RD, 16'h0);
        chk("load", sout, 16'h1000);
        cyc(IDL, 16'h0);
        chk("load", sout, 16'h1001);
        $display("Test load done");
        cmd(1'b1, SEL_FLOW, 16'h0, 16'h0);
        cyc(J2, 16'h0);
        for (int i = 0; i < 3; i++)
            cyc(WR, 16'h2000 + 16'(i));
        // Writes chain 0x22 to 0x10, reads chain 0x13 to 0x20
        for (int i = 0; i < 6; i++) begin
            cyc(RD, 16'h0);
            exp_w = (i < 5) ? 16'h0fff + 16'(i) : 16'h2000;
            if (i > 0)
                chk("chain", sout, exp_w);
        end
        cyc(IDL, 16'h0);
        chk("chain flags", {f1_n, f2_n}, 2'h0);
        cmd(1'b0, SEL_FLAGS, 16'h0, 16'h0003);
        cmd(1'b1, SEL_FLAGS, 16'h0, 16'h0);
        cmd(1'b1, SEL_END_ONE, 16'h0011, 16'h0);
        cmd(1'b1, SEL_FLOW, {14'h0, MODE_STOP}, 16'h0);
        cyc(J1, 16'h0);
        repeat (2) cyc(RD, 16'h0);
        // Bus turnaround before the write
        cyc(IDL, 16'h0);
        cyc(WR, 16'h5555);
        cyc(IDL, 16'h0);
        cmd(1'b0, SEL_FLOW, 16'h0, 16'h0011);
        cmd(1'b1, SEL_FLOW, {14'h0, MODE_STOP}, 16'h0);
        cmd(1'b0, SEL_FLOW, 16'h0, {14'h0, MODE_STOP});
        cyc(RD, 16'h0);
        cyc(RD, 16'h0);
        chk("stop", sout, 16'h1002);
        cyc(IDL, 16'h0);
        chk("release", sout, 16'h1003);
        cmd(1'b1, SEL_FLOW, 16'h000c, 16'h0);
        cyc(J2, 16'h0);
        repeat (3) cyc(RD, 16'h0);
        cyc(IDL, 16'h0);
        chk("mask flags", {f1_n, f2_n}, 2'h1);
        cmd(1'b0, SEL_FLAGS, 16'h0, 16'h0003);
        cyc(LD, 16'h1fff);
        cyc(IDL, 16'h0);
        cyc(WR, 16'haaaa);
        cyc(WR, 16'h5a5a);
        cyc(LD, 16'h0000);
        cyc(IDL, 16'h0);
        cyc(RD, 16'h0);
        cyc(IDL, 16'h0);
        chk("wrap", sout, 16'h5a5a);
        $display("Test modes done");
        cyc(RD, 16'h0);
        cyc(RD, 16'h0);
        chk("driving", soe_n, 1'b0);
        @(posedge core_clk);
        arst_n <= 1'b0;
        #1;
        chk("reset", {soe_n, f1_n, f2_n}, 3'h7);
        cyc(IDL, 16'h0);
        @(posedge core_clk);
        arst_n <= 1'b1;
        cmd(1'b0, SEL_END_ONE, 16'h0, {3'h0, RST_END_ONE});
        cmd(1'b0, SEL_FLOW, 16'h0, 16'h0);
        chk("contention", {15'h0, clash}, 16'h0);
        $display("Test reset done");
        end_of_test();
    end
endmodule
